//--- rtl/csf_cfg.svh
/*
  Constants of the clock switch, fail-safe monitor and reset sequencer:
  register offsets, field positions, keys, encodings and timing figures.
  Assumes it is included by its bare name before any use.
*/
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define CSF_ADDR_OSC 8'h00
`define CSF_ADDR_RST 8'h04
`define CSF_CUR_LSB 12
`define CSF_NEW_LSB 8
`define CSF_LOCK_BIT 5
`define CSF_CF_BIT 3
`define CSF_LPEN_BIT 1
`define CSF_GO_BIT 0
`define CSF_KEY_LO_A 8'h46
`define CSF_KEY_LO_B 8'h57
`define CSF_KEY_HI_A 8'h78
`define CSF_KEY_HI_B 8'h9A
`define CSF_RSTAT_RST 8'h03
`define CSF_RS_POR 0
`define CSF_RS_BOR 1
`define CSF_RS_EXT 2
`define CSF_RS_SW 3
`define CSF_RS_WDT 4
`define CSF_RS_SLP 5
`define CSF_RS_TRAP 6
`define CSF_RS_ILL 7
// ----------------------------------------
// Encodings
// ----------------------------------------
`define CSF_GRP_SEC 2'b00
`define CSF_GRP_FRC 2'b01
`define CSF_GRP_SLOW_INTERNAL_RC 2'b10
`define CSF_GRP_PRI 2'b11
`define CSF_PM_FRC4 4'h1
`define CSF_PM_FRC16 4'h3
`define CSF_PM_FRC8 4'hA
// ----------------------------------------
// Timing
// ----------------------------------------
`define CSF_CLK_NS 40
`define CSF_POWER_ON_DELAY_NS 10000
`define CSF_POWERUP_TIMER_A_MS 4
`define CSF_POWERUP_TIMER_B_MS 16
`define CSF_POWERUP_TIMER_C_MS 64
`define CSF_FILT_NS 400
`define CSF_WIN_TICKS 8
`endif

//--- rtl/csf_pkg.sv
/*
  Types of the clock switch, fail-safe monitor and reset sequencer.
  Assumes nothing of its surroundings.
*/
package csf_pkg;
  typedef enum logic [2:0] {
    ST_POR  = 3'b000,
    ST_POWERUP_TIMER = 3'b001,
    ST_CHK  = 3'b010,
    ST_WQ1  = 3'b011,
    ST_RUN  = 3'b100
  } csf_state_t;
  typedef enum logic [1:0] {
    ULK_IDLE = 2'b00,
    ULK_KEY1 = 2'b01,
    ULK_OPEN = 2'b10
  } csf_ulk_t;
  typedef struct packed {
    logic primary;
    logic secondary;
    logic fast_internal_rc;
    logic slow_internal_rc;
    logic lp_keep;
  } csf_osc_sel_t;
  typedef struct packed {
    logic       act;
    logic       wr;
    logic       osc;
    logic       rst;
    logic [2:0] size;
    logic [1:0] lane;
  } csf_dphase_t;
endpackage

//--- rtl/csf_top.sv
/*
  Clock group switch with write-unlock guard, fail-safe clock monitor and
  power-up reset sequencer, reached as an AHB-Lite slave.
  Assumes pins pass through this block's synchronisers, sys_clk_mon is a
  divided copy of the system clock, and same-clock inputs are pulses.
*/
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "csf_cfg.svh"
module csf_top #(
  parameter int POWERUP_TIMER_A_CYC = `CSF_POWERUP_TIMER_A_MS * 1000000 / `CSF_CLK_NS,
  parameter int POWERUP_TIMER_B_CYC = `CSF_POWERUP_TIMER_B_MS * 1000000 / `CSF_CLK_NS,
  parameter int POWERUP_TIMER_C_CYC = `CSF_POWERUP_TIMER_C_MS * 1000000 / `CSF_CLK_NS
) (
  input  logic                  clk,
  input  logic                  rst_n,
  input  logic                  hsel,
  input  logic [7:0]            haddr,
  input  logic [1:0]            htrans,
  input  logic                  hwrite,
  input  logic [2:0]            hsize,
  input  logic [31:0]           hwdata,
  input  logic                  hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  logic [1:0]            monitor_select_cfg,
  input  logic [1:0]            initial_group_cfg,
  input  logic [3:0]            primary_mode_cfg,
  input  logic [1:0]            powerup_timer_cfg,
  input  logic                  soft_watchdog_enable,
  input  logic                  sleep_mode,
  input  logic                  por_pulse,
  input  logic                  brownout_reset,
  input  logic                  external_reset_pin_i,
  output logic                  external_reset_pin_o,
  output logic                  external_reset_pin_oe_n,
  input  logic                  watchdog_timeout,
  input  logic                  reset_instr,
  input  logic                  trap_lockup,
  input  logic                  illegal_op,
  input  logic                  slow_rc_clk,
  input  logic                  sys_clk_mon,
  input  logic                  pll_lock,
  input  logic                  osc_started,
  input  logic                  first_phase_clock,
  output logic                  internal_system_reset,
  output logic                  go_reset_vector,
  output logic                  clock_fail_trap,
  output logic                  core_clock_hold,
  output csf_pkg::csf_osc_sel_t osc_select,
  output logic                  slow_internal_rc_enable,
  output logic                  watchdog_tick
);
  localparam logic [20:0] POWER_ON_DELAY_M1 =
    21'((`CSF_POWER_ON_DELAY_NS + `CSF_CLK_NS - 1) / `CSF_CLK_NS - 1);
  localparam logic [5:0] FILT_M1 =
    6'((`CSF_FILT_NS + `CSF_CLK_NS - 1) / `CSF_CLK_NS - 1);
  localparam logic [3:0] WIN_M1 = 4'(`CSF_WIN_TICKS - 1);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [6:0] sy1_reg;
  logic [6:0] sy2_reg;
  logic [6:0] sy3_reg;
  wire  [6:0] pin_in = {osc_started, pll_lock, sys_clk_mon, slow_rc_clk,
                        external_reset_pin_i, brownout_reset, por_pulse};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_reg <= 7'h04;
      sy2_reg <= 7'h04;
      sy3_reg <= 7'h04;
    end else begin
      sy1_reg <= pin_in;
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  wire por_rise  = sy2_reg[0] & ~sy3_reg[0];
  wire bor_rise  = sy2_reg[1] & ~sy3_reg[1];
  wire pin_low   = ~sy2_reg[2];
  wire slow_tick = sy2_reg[3] & ~sy3_reg[3];
  wire mon_edge  = sy2_reg[4] ^ sy3_reg[4];
  wire lock_s    = sy2_reg[5];
  wire ost_s     = sy2_reg[6];

  // ----------------------------------------
  // Reset pin filter
  // ----------------------------------------
  // Pin is input only, so internal resets can never pull it low
  assign external_reset_pin_o    = 1'b1;
  assign external_reset_pin_oe_n = 1'b1;

  logic [5:0] filt_reg;
  wire        ext_evt = pin_low & (filt_reg == FILT_M1);
  wire [5:0]  filt_next = !pin_low ? 6'h00 :
                          (filt_reg == FILT_M1) ? 6'h3F :
                          (filt_reg == 6'h3F) ? filt_reg : filt_reg + 6'h01;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) filt_reg <= 6'h00;
    else        filt_reg <= filt_next;
  end

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  wire switch_en = ~monitor_select_cfg[1];
  wire mon_en    = (monitor_select_cfg == 2'b00);
  wire pll_used  = (primary_mode_cfg[2] & |primary_mode_cfg[1:0]) |
                   (primary_mode_cfg == `CSF_PM_FRC4) |
                   (primary_mode_cfg == `CSF_PM_FRC16) |
                   (primary_mode_cfg == `CSF_PM_FRC8);
  // External RC and clock input need no start-up
  wire pri_noxtal = primary_mode_cfg[3] & ~pll_used;
  wire pri_ready  = (pri_noxtal | ost_s) & (~pll_used | lock_s);

  // ----------------------------------------
  // Failure detector window
  // ----------------------------------------
  logic [3:0] win_reg;
  logic [3:0] edge_reg;
  logic       alive_reg;
  wire        win_end   = slow_tick & (win_reg == WIN_M1);
  wire        no_edge   = (edge_reg == 4'h0) & ~mon_edge;
  wire        sys_alive = alive_reg | (edge_reg != 4'h0);
  wire [3:0]  win_next  = !slow_tick ? win_reg :
                          win_end ? 4'h0 : win_reg + 4'h1;
  wire [3:0]  edge_next = win_end ? {3'b000, mon_edge} :
                          (mon_edge & ~&edge_reg) ? edge_reg + 4'h1 : edge_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_reg   <= 4'h0;
      edge_reg  <= 4'h0;
      alive_reg <= 1'b0;
    end else begin
      win_reg  <= win_next;
      edge_reg <= edge_next;
      if (win_end) alive_reg <= ~no_edge;
    end
  end

  // ----------------------------------------
  // Power-up sequencer
  // ----------------------------------------
  csf_pkg::csf_state_t state_reg;
  csf_pkg::csf_state_t state_next;
  logic [20:0]         cnt_reg;
  logic [20:0]         cnt_next;
  logic                internal_system_reset_reg;
  logic                vec_reg;
  logic                sleep_d_reg;

  wire pwr_evt   = por_rise | bor_rise;
  wire other_rst = ext_evt | watchdog_timeout | reset_instr | trap_lockup |
                   illegal_op;
  wire st_por    = (state_reg == csf_pkg::ST_POR);
  wire st_chk    = (state_reg == csf_pkg::ST_CHK);
  wire st_run    = (state_reg == csf_pkg::ST_RUN);
  wire wake      = sleep_d_reg & ~sleep_mode;
  wire [20:0] powerup_timer_lim = (powerup_timer_cfg == 2'b00) ? 21'd0 :
                         (powerup_timer_cfg == 2'b01) ? 21'(POWERUP_TIMER_A_CYC) :
                         (powerup_timer_cfg == 2'b10) ? 21'(POWERUP_TIMER_B_CYC) :
                         21'(POWERUP_TIMER_C_CYC);
  wire powerup_timer_done = (powerup_timer_lim == 21'd0) | (cnt_reg == powerup_timer_lim - 21'd1);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 21'd1;
    if (pwr_evt) begin
      state_next = csf_pkg::ST_POR;
      cnt_next   = 21'd0;
    end else if (other_rst & st_run) begin
      state_next = csf_pkg::ST_WQ1;
    end else begin
      case (state_reg)
        csf_pkg::ST_POR: begin
          if (cnt_reg == POWER_ON_DELAY_M1) begin
            state_next = csf_pkg::ST_POWERUP_TIMER;
            cnt_next   = 21'd0;
          end
        end
        csf_pkg::ST_POWERUP_TIMER: begin
          if (powerup_timer_done) begin
            state_next = csf_pkg::ST_CHK;
          end
        end
        csf_pkg::ST_CHK: begin
          state_next = csf_pkg::ST_WQ1;
        end
        csf_pkg::ST_WQ1: begin
          if (first_phase_clock) begin
            state_next = csf_pkg::ST_RUN;
          end
        end
        csf_pkg::ST_RUN: begin
          state_next = csf_pkg::ST_RUN;
        end
        default: begin
          state_next = csf_pkg::ST_POR;
        end
      endcase
    end
    if (state_next == csf_pkg::ST_RUN || state_next == csf_pkg::ST_WQ1) begin
      cnt_next = 21'd0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= csf_pkg::ST_POR;
      cnt_reg     <= 21'd0;
      internal_system_reset_reg  <= 1'b1;
      vec_reg     <= 1'b0;
      sleep_d_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      internal_system_reset_reg  <= (state_next != csf_pkg::ST_RUN);
      vec_reg     <= (state_reg == csf_pkg::ST_WQ1) & first_phase_clock;
      sleep_d_reg <= sleep_mode;
    end
  end

  assign internal_system_reset = internal_system_reset_reg;
  assign go_reset_vector       = vec_reg;

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  csf_pkg::csf_dphase_t dp_reg;
  logic [31:0]          rdat_reg;
  wire  ap_take = hsel & htrans[1] & hready;
  wire  ap_osc  = (haddr[7:2] == 6'(`CSF_ADDR_OSC >> 2));
  wire  ap_rst  = (haddr[7:2] == 6'(`CSF_ADDR_RST >> 2));
  wire csf_pkg::csf_dphase_t dp_next = '{act: ap_take, wr: ap_take & hwrite,
                                         osc: ap_osc, rst: ap_rst,
                                         size: hsize, lane: haddr[1:0]};

  // ----------------------------------------
  // Unlock guards, one per byte lane
  // ----------------------------------------
  csf_pkg::csf_ulk_t ulk_reg [2];
  logic [1:0]        wr_ok;

  for (genvar l = 0; l < 2; l++) begin : g_lane
    wire [7:0] wb    = hwdata[8*l +: 8];
    wire [7:0] key_a = (l == 0) ? `CSF_KEY_LO_A : `CSF_KEY_HI_A;
    wire [7:0] key_b = (l == 0) ? `CSF_KEY_LO_B : `CSF_KEY_HI_B;
    wire       bw    = dp_reg.wr & dp_reg.osc & (dp_reg.size == 3'b000) &
                       (dp_reg.lane == 2'(l));
    csf_pkg::csf_ulk_t nx;
    always_comb begin
      nx = csf_pkg::ULK_IDLE;
      case (ulk_reg[l])
        csf_pkg::ULK_IDLE: nx = (bw & (wb == key_a)) ? csf_pkg::ULK_KEY1 :
                                csf_pkg::ULK_IDLE;
        csf_pkg::ULK_KEY1: nx = (bw & (wb == key_b)) ? csf_pkg::ULK_OPEN :
                                csf_pkg::ULK_IDLE;
        csf_pkg::ULK_OPEN: nx = csf_pkg::ULK_IDLE;
        default:           nx = csf_pkg::ULK_IDLE;
      endcase
    end
    assign wr_ok[l] = bw & (ulk_reg[l] == csf_pkg::ULK_OPEN);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)          ulk_reg[l] <= csf_pkg::ULK_IDLE;
      else if (dp_reg.act) ulk_reg[l] <= nx;
    end
  end

  // ----------------------------------------
  // Oscillator control state
  // ----------------------------------------
  logic [1:0] cur_reg;
  logic [1:0] new_reg;
  logic       go_reg;
  logic       cf_reg;
  logic       lpen_reg;
  logic       trap_reg;
  wire [7:0]  wb_lo = hwdata[7:0];
  wire [7:0]  wb_hi = hwdata[15:8];

  function automatic logic grp_ready(input logic [1:0] g, input logic pri,
                                     input logic lp);
    case (g)
      `CSF_GRP_PRI: grp_ready = pri;
      `CSF_GRP_SEC: grp_ready = lp;
      default:      grp_ready = 1'b1;
    endcase
  endfunction

  // Switching disabled: config drives the clock, field just reports it
  wire [1:0] cur_grp   = switch_en ? cur_reg : initial_group_cfg;
  wire       cur_ready = grp_ready(cur_grp, pri_ready, lpen_reg);
  wire       new_ready = grp_ready(new_reg, pri_ready, lpen_reg);
  wire       mon_armed = mon_en & ~sleep_mode & (cur_grp != `CSF_GRP_FRC);
  wire       fail_evt  = mon_armed & ((st_run & win_end & no_edge) |
                         (st_chk & ~(cur_ready & sys_alive)) |
                         (st_run & wake & ~cur_ready));
  wire       sw_done   = go_reg & new_ready & ~wr_ok[0] & ~fail_evt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_reg  <= `CSF_GRP_PRI;
      new_reg  <= `CSF_GRP_PRI;
      go_reg   <= 1'b0;
      cf_reg   <= 1'b0;
      lpen_reg <= 1'b0;
      trap_reg <= 1'b0;
    end else begin
      trap_reg <= fail_evt;
      if (st_por) begin
        cur_reg <= initial_group_cfg;
        new_reg <= initial_group_cfg;
        go_reg  <= 1'b0;
        cf_reg  <= 1'b0;
      end else if (fail_evt) begin
        cur_reg <= `CSF_GRP_FRC;
        cf_reg  <= 1'b1;
        go_reg  <= 1'b0;
      end else begin
        if (wr_ok[0]) go_reg <= wb_lo[`CSF_GO_BIT] & switch_en;
        else if (sw_done) go_reg <= 1'b0;
        if (sw_done) cur_reg <= new_reg;
      end
      if (wr_ok[0]) lpen_reg <= wb_lo[`CSF_LPEN_BIT];
      if (wr_ok[1] & ~st_por) new_reg <= wb_hi[`CSF_NEW_LSB - 8 +: 2];
    end
  end

  // ----------------------------------------
  // Reset cause status
  // ----------------------------------------
  logic [7:0] rstat_reg;
  wire  [7:0] rs_set = (8'(por_rise) << `CSF_RS_POR) |
                       (8'(pwr_evt) << `CSF_RS_BOR) |
                       (8'(ext_evt) << `CSF_RS_EXT) |
                       (8'(reset_instr) << `CSF_RS_SW) |
                       (8'(watchdog_timeout) << `CSF_RS_WDT) |
                       (8'(ext_evt & sleep_mode) << `CSF_RS_SLP) |
                       (8'(trap_lockup) << `CSF_RS_TRAP) |
                       (8'(illegal_op) << `CSF_RS_ILL);
  wire  [7:0] rs_clr = (dp_reg.wr & dp_reg.rst & (dp_reg.lane == 2'b00)) ?
                       hwdata[7:0] : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rstat_reg <= `CSF_RSTAT_RST;
    else        rstat_reg <= (rstat_reg & ~rs_clr) | rs_set;
  end

  // ----------------------------------------
  // Read data and bus answer
  // ----------------------------------------
  wire [15:0] osc_view = (16'(cur_grp) << `CSF_CUR_LSB) |
                         (16'(new_reg) << `CSF_NEW_LSB) |
                         (16'(lock_s) << `CSF_LOCK_BIT) |
                         (16'(cf_reg) << `CSF_CF_BIT) |
                         (16'(lpen_reg) << `CSF_LPEN_BIT) |
                         (16'(go_reg) << `CSF_GO_BIT);
  wire [31:0] rd_word  = ap_osc ? {16'h0000, osc_view} :
                         ap_rst ? {24'h000000, rstat_reg} : 32'h00000000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_reg   <= '0;
      rdat_reg <= 32'h00000000;
    end else begin
      dp_reg <= dp_next;
      if (ap_take & ~hwrite) rdat_reg <= rd_word;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdat_reg;

  // ----------------------------------------
  // Clock source outputs
  // ----------------------------------------
  csf_pkg::csf_osc_sel_t osel_reg;
  logic                  hold_reg;
  logic                  slow_en_reg;
  logic                  wdt_reg;
  wire csf_pkg::csf_osc_sel_t osel_next = '{
    primary:   (cur_grp == `CSF_GRP_PRI),
    secondary: (cur_grp == `CSF_GRP_SEC) & lpen_reg,
    fast_internal_rc:       (cur_grp == `CSF_GRP_FRC),
    slow_internal_rc:      (cur_grp == `CSF_GRP_SLOW_INTERNAL_RC),
    lp_keep:   lpen_reg};
  // PLL lock gates the core clock; dead clock with no monitor freezes it
  wire hold_next = ((cur_grp == `CSF_GRP_PRI) & pll_used & ~lock_s) |
                   (~mon_en & ~sys_alive);
  wire slow_next = mon_en ? ~sleep_mode :
                   (soft_watchdog_enable | ~st_run |
                    (cur_grp == `CSF_GRP_SLOW_INTERNAL_RC));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osel_reg    <= '0;
      hold_reg    <= 1'b1;
      slow_en_reg <= 1'b1;
      wdt_reg     <= 1'b0;
    end else begin
      osel_reg    <= osel_next;
      hold_reg    <= hold_next;
      slow_en_reg <= slow_next;
      wdt_reg     <= slow_tick;
    end
  end

  assign osc_select              = osel_reg;
  assign core_clock_hold         = hold_reg;
  assign slow_internal_rc_enable = slow_en_reg;
  assign watchdog_tick           = wdt_reg;
  assign clock_fail_trap         = trap_reg;

endmodule

//--- bench/csf_chk.sv
/* Port checker of the clock switch block.
   Assumes it is bound into csf_top and sees its ports only. */
`timescale 1ns/1ps
module csf_chk (
  input logic                  clk,
  input logic                  rst_n,
  input logic                  hsel,
  input logic [1:0]            htrans,
  input logic                  hwrite,
  input logic                  hready,
  input logic                  hreadyout,
  input logic                  hresp,
  input logic [31:0]           hrdata,
  input logic [1:0]            monitor_select_cfg,
  input logic                  sleep_mode,
  input logic                  first_phase_clock,
  input logic                  internal_system_reset,
  input logic                  clock_fail_trap,
  input logic                  external_reset_pin_oe_n,
  input csf_pkg::csf_osc_sel_t osc_select,
  input logic                  slow_internal_rc_enable,
  input logic                  watchdog_tick
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Properties
  // ----
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus answer not ready okay");
  property p_pin; external_reset_pin_oe_n; endproperty
  a_pin: assert property (p_pin) else $error("reset pin driven");
  property p_trp; clock_fail_trap |=> !clock_fail_trap; endproperty
  a_trp: assert property (p_trp) else $error("trap not a pulse");
  property p_frc; clock_fail_trap |-> ##[0:2] osc_select.fast_internal_rc; endproperty
  a_frc: assert property (p_frc) else $error("no fast rc after trap");
  property p_hot;
    $onehot0({osc_select.primary, osc_select.secondary, osc_select.fast_internal_rc, osc_select.slow_internal_rc});
  endproperty
  a_hot: assert property (p_hot) else $error("two clock groups on");
  property p_wdt; watchdog_tick |=> !watchdog_tick; endproperty
  a_wdt: assert property (p_wdt) else $error("tick not a pulse");
  // Trap is registered, so the config must have stood one cycle already
  property p_off; monitor_select_cfg[1] && $past(monitor_select_cfg[1]) |-> !clock_fail_trap;
  endproperty
  a_off: assert property (p_off) else $error("trap with monitor off");
  property p_lp; (monitor_select_cfg == 2'b00 && !sleep_mode) [*2] |-> slow_internal_rc_enable;
  endproperty
  a_lp: assert property (p_lp) else $error("slow rc stopped");
  property p_rel;
    $fell(internal_system_reset) |-> $past(first_phase_clock) || $past(first_phase_clock, 2);
  endproperty
  a_rel: assert property (p_rel) else $error("release off phase");
  property p_rd; !$stable(hrdata) |-> $past(hsel && htrans[1] && !hwrite && hready);
  endproperty
  a_rd: assert property (p_rd) else $error("read data moved");
  c_trp: cover property (clock_fail_trap);
  c_rel: cover property ($fell(internal_system_reset));
  c_wdt: cover property (watchdog_tick);
endmodule
bind csf_top csf_chk u_chk (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .monitor_select_cfg(monitor_select_cfg), .sleep_mode(sleep_mode),
  .first_phase_clock(first_phase_clock), .internal_system_reset(internal_system_reset),
  .clock_fail_trap(clock_fail_trap), .external_reset_pin_oe_n(external_reset_pin_oe_n),
  .osc_select(osc_select), .slow_internal_rc_enable(slow_internal_rc_enable),
  .watchdog_tick(watchdog_tick));

//--- bench/test_clock_switch_failsafe_reset.sv
/* Self-checking bench of the clock switch block.
   Assumes csf_pkg, csf_top and the checker are compiled first. */
`timescale 1ns/1ps
module test_clock_switch_failsafe_reset;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0, monitor_select_cfg = 0, initial_group_cfg = 1, powerup_timer_cfg = 1;
  logic [2:0] hsize = 0;
  logic [31:0] hrdata, hwdata = 0;
  logic [3:0] primary_mode_cfg = 4'h4;
  logic [6:0] cz = 0;
  logic soft_watchdog_enable = 0, sleep_mode = 0, slow_rc_clk = 0, sys_clk_mon = 0;
  logic pll_lock = 1, osc_started = 0, first_phase_clock = 0, mon_on = 1, rd_ph = 0;
  logic external_reset_pin_o, external_reset_pin_oe_n, internal_system_reset;
  logic go_reset_vector, clock_fail_trap, core_clock_hold, slow_internal_rc_enable;
  logic watchdog_tick;
  logic [63:0] q[$], e;
  csf_pkg::csf_osc_sel_t osc_select;
  int fails = 0, tests_run = 0, seed = 31, ntrap = 0, nw = 0, n0, cyc = 0, nv = 0;
  logic [7:0] ex [9] = '{8'h03, 8'h02, 8'h08, 8'h10, 8'h40, 8'h80, 8'h04, 8'h00, 8'h24};
  int hl [9] = '{4, 4, 1, 1, 1, 1, 12, 5, 12};
  int bi [9] = '{0, 1, 2, 3, 4, 5, 6, 6, 6};
  localparam logic [31:0] M = 32'h0000332B;
  assign hready = hreadyout;
  // Small power-up counts keep the run short
  csf_top #(.POWERUP_TIMER_A_CYC(20), .POWERUP_TIMER_B_CYC(40), .POWERUP_TIMER_C_CYC(80)) u_dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .monitor_select_cfg(monitor_select_cfg), .initial_group_cfg(initial_group_cfg),
    .primary_mode_cfg(primary_mode_cfg), .powerup_timer_cfg(powerup_timer_cfg),
    .soft_watchdog_enable(soft_watchdog_enable), .sleep_mode(sleep_mode),
    .por_pulse(cz[0]), .brownout_reset(cz[1]), .reset_instr(cz[2]),
    .watchdog_timeout(cz[3]), .trap_lockup(cz[4]), .illegal_op(cz[5]),
    .external_reset_pin_i(~cz[6]), .external_reset_pin_o(external_reset_pin_o),
    .external_reset_pin_oe_n(external_reset_pin_oe_n), .slow_rc_clk(slow_rc_clk),
    .sys_clk_mon(sys_clk_mon), .pll_lock(pll_lock), .osc_started(osc_started),
    .first_phase_clock(first_phase_clock), .internal_system_reset(internal_system_reset),
    .go_reset_vector(go_reset_vector), .clock_fail_trap(clock_fail_trap),
    .core_clock_hold(core_clock_hold), .osc_select(osc_select),
    .slow_internal_rc_enable(slow_internal_rc_enable), .watchdog_tick(watchdog_tick));
  // ----
  // Clocks, counters and read monitor
  // ----
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    first_phase_clock <= (cyc[1:0] == 2'b11);
    slow_rc_clk <= cyc[3];
    sys_clk_mon <= mon_on ? ~sys_clk_mon : sys_clk_mon;
    ntrap <= ntrap + clock_fail_trap;
    nw <= nw + watchdog_tick;
    nv <= nv + go_reset_vector;
    if (rd_ph && hready) begin
      e = q.pop_front();
      chk(hrdata & e[63:32], e[31:0]);
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      fails++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [2:0] s,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= s;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph <= !w;
    do @(posedge clk); while (hready !== 1'b1);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    q.push_back({m, x});
    bus(a, 1'b0, 3'b010, 32'h00000000);
  endtask
  task automatic wb(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, 3'b000, a[0] ? {16'h0000, d, 8'h00} : {24'h000000, d});
  endtask
  task automatic wisr(input logic v);
    for (int k = 0; k < 3000 && internal_system_reset !== v; k++) @(posedge clk);
    chk(internal_system_reset, v);
  endtask
  task automatic close_out;
    $display("Counts: fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wisr(1'b0);
    rd(8'h00, M, 32'h1120);
    wb(8'h01, 8'h78);
    wb(8'h01, 8'h9A);
    wb(8'h01, 8'h33);
    rd(8'h00, M, 32'h1320);
    wb(8'h01, 8'h78);
    rd(8'h00, M, 32'h1320);
    wb(8'h01, 8'h9A);
    wb(8'h01, 8'h02 & 8'($random(seed)));
    rd(8'h00, M, 32'h1320);
    wb(8'h00, 8'h46);
    wb(8'h00, 8'h57);
    wb(8'h00, 8'h01);
    rd(8'h00, M, 32'h1321);
    osc_started <= 1'b1;
    for (int k = 0; k < 200 && osc_select.primary !== 1'b1; k++) @(posedge clk);
    rd(8'h00, M, 32'h3320);
    n0 = nw;
    mon_on <= 1'b0;
    for (int k = 0; k < 600 && clock_fail_trap !== 1'b1; k++) @(posedge clk);
    @(posedge clk);
    chk(ntrap, 1);
    chk(nw > n0, 1);
    rd(8'h00, M, 32'h1328);
    mon_on <= 1'b1;
    bus(8'h10, 1'b1, 3'b010, $random(seed));
    rd(8'h10, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 9; i++) begin
      bus(8'h04, 1'b1, 3'b010, 32'h000000FF);
      powerup_timer_cfg <= 2'($random(seed));
      cz[bi[i]] <= 1'b1;
      sleep_mode <= (i == 8);
      repeat (hl[i]) @(posedge clk);
      cz <= 7'h00;
      sleep_mode <= 1'b0;
      // A filtered glitch never starts a reset, so it has nothing to wait on
      if (ex[i] != 8'h00) begin
        wisr(1'b1);
        wisr(1'b0);
      end
      else repeat (40) @(posedge clk);
      rd(8'h04, 32'h000000FF, {24'h0, ex[i]});
    end
    monitor_select_cfg <= 2'b10;
    initial_group_cfg <= 2'b11;
    mon_on <= 1'b0;
    n0 = ntrap;
    repeat (400) @(posedge clk);
    chk(ntrap, n0);
    chk(core_clock_hold, 1'b1);
    chk(external_reset_pin_o, 1'b1);
    chk(nv, 9);
    close_out;
  end
  initial begin
    #(40 * 30000);
    fails++;
    close_out;
  end
endmodule
